// ---- hw/xcvr_ctrl.v ----
// controller driving a low/full speed transceiver through its logic pins
// assumes transceiver pins are asynchronous to core_clk; software on classic wishbone
//
// Overview of operation
// RL1: to receive, hold direction select high and suspend low; the transceiver then drives the line levels and rx level.
// RL2: in receive the line levels follow the bus lines and rx level is 0 for J-low pair and 1 for the opposite.
// RL3: a bus with both lines low gives both line levels low while rx level keeps its value from before.
// RL4: to transmit, hold direction select low and suspend low; the transceiver drives the bus and reads the line pins.
// RL5: differential transmit needs mode high, direction and suspend low and data on both line pins.
// RL6: single-ended transmit needs mode, suspend, direction and the minus pin low, data on the plus pin.
// RL7: with suspend high the bus floats, rx level reads 0 and the line-level pins stay outputs of the transceiver.
// RL8: the bus pull-up is connected only while the attach control is high.
// RL9: in differential transmit the bus follows the two line pins, both low giving SE0.
// RL10: in single-ended transmit a high minus pin forces SE0 on the bus.
// RL11: the speed select puts the pull-up on D+ when high and on D- when low.
`timescale 1ns/1ps
`include "xcvr_ctrl_defines.vh"
module xcvr_ctrl (
  input wire core_clk, // core clock, 250 MHz
  input wire resetn, // synchronous reset, active low
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write enable
  input wire [3:0] wb_adr_i, // wishbone word address
  input wire [3:0] wb_sel_i, // wishbone byte selects
  input wire [31:0] wb_dat_i, // wishbone write data
  output reg [31:0] wb_dat_o, // wishbone read data
  output reg wb_ack_o, // wishbone acknowledge
  output reg dir_rx_q, // direction select, high to receive
  output reg low_power_hold_q, // suspend select
  output reg attach_q, // attach control for the pull-up
  output reg speed_full_q, // speed select, high for full speed
  output reg mode_diff_q, // mode select, high for differential input
  input wire line_plus_level_i, // plus line pin, input side
  output reg line_plus_level_o, // plus line pin, output side
  output reg line_plus_level_oe_n, // plus line output enable, low drives
  input wire line_minus_level_i, // minus line pin, input side
  output reg line_minus_level_o, // minus line pin, output side
  output reg line_minus_level_oe_n, // minus line output enable, low drives
  input wire rx_diff_level // received differential level pin
);
  localparam ST_RX = 3'b001;
  localparam ST_TURN = 3'b010;
  localparam ST_TX = 3'b100;

  reg [31:0] ctrl_q;
  reg [1:0] txdata_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [3:0] turn_q;
  reg [7:0] hist_q;
  reg rx_prev_q;
  reg rx_prev_d;
  reg [7:0] hist_d;
  reg [3:0] turn_d;
  reg [31:0] rd_d;
  reg ack_d;
  reg [31:0] ctrl_d;
  reg [1:0] txdata_d;
  reg dir_rx_d;
  reg low_power_hold_d;
  reg attach_d;
  reg speed_d;
  reg mode_d;
  reg line_oe_n_d;
  reg line_plus_d;
  reg line_minus_d;
  wire [`SYNC_PINS-1:0] pin_raw;
  wire [`SYNC_PINS-1:0] pin_s;
  wire plus_s;
  wire minus_s;
  wire rcv_s;
  wire se0_s;
  wire want_rx;
  wire take_wr;
  wire take_rd;
  reg [31:0] status_word;

  // all three transceiver outputs are asynchronous to core_clk
  assign pin_raw = {rx_diff_level, line_minus_level_i, line_plus_level_i};
  assign plus_s = pin_s[0];
  assign minus_s = pin_s[1];
  assign rcv_s = pin_s[2];

  genvar gi;
  generate
    for (gi = 0; gi < `SYNC_PINS; gi = gi + 1) begin : g_sync
      pin_sync3 u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .pin_in(pin_raw[gi]),
        .level_q(pin_s[gi])
      );
    end
  endgenerate

  function sel_hit;
    input [3:0] adr;
    input [3:0] want;
    begin
      sel_hit = (adr == want);
    end
  endfunction

  assign take_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign take_rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign want_rx = ctrl_q[`CTRL_RX_BIT];
  // RL3 se0 seen on the line levels
  assign se0_s = ~plus_s & ~minus_s;

  // status word, live line view
  always @* begin
    status_word = 32'h00000000;
    status_word[`ST_RX_BIT] = rcv_s;
    status_word[`ST_PLUS_BIT] = plus_s;
    status_word[`ST_MINUS_BIT] = minus_s;
    status_word[`ST_SE0_BIT] = se0_s;
    status_word[`ST_FULL_BIT] = speed_full_q;
    status_word[`ST_ILLEGAL_BIT] = plus_s & minus_s;
    status_word[`ST_TURN_BIT] = (state_q == ST_TURN);
  end

  // next values of the software registers
  always @* begin
    ctrl_d = ctrl_q;
    txdata_d = txdata_q;
    if (take_wr && wb_sel_i[0]) begin
      if (sel_hit(wb_adr_i, `ADR_CTRL))
        ctrl_d = {24'h000000, 3'h0, wb_dat_i[4:0]};
      if (sel_hit(wb_adr_i, `ADR_TXDATA))
        txdata_d = wb_dat_i[1:0];
    end
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q <= `CTRL_RESET;
      txdata_q <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      txdata_q <= txdata_d;
    end
  end

  // read data, unmapped words read as zero
  always @* begin
    case (wb_adr_i)
      `ADR_CTRL: rd_d = ctrl_q;
      `ADR_TXDATA: rd_d = {30'h00000000, txdata_q};
      `ADR_STATUS: rd_d = status_word;
      `ADR_RXHIST: rd_d = {24'h000000, hist_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  // ack one cycle after the request, never two cycles in a row
  always @* begin
    ack_d = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= ack_d;
      if (take_rd)
        wb_dat_o <= rd_d;
    end
  end

  // receive history: rcv shifted in on each change, frozen through se0, suspend, turnaround and transmit
  always @* begin
    hist_d = hist_q;
    rx_prev_d = rx_prev_q;
    if (state_q == ST_RX && !low_power_hold_q && !se0_s) begin
      rx_prev_d = rcv_s;
      if (rcv_s != rx_prev_q)
        hist_d = {hist_q[6:0], rcv_s};
    end
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      hist_q <= 8'h00;
      rx_prev_q <= 1'b0;
    end else begin
      hist_q <= hist_d;
      rx_prev_q <= rx_prev_d;
    end
  end

  // direction turnaround: keep the line pins released for a while before transmit; leaving transmit releases them as direction goes high
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RX: begin
        if (!want_rx)
          state_d = ST_TURN;
      end
      ST_TURN: begin
        if (turn_q == `TURN_CYCLES)
          state_d = want_rx ? ST_RX : ST_TX;
      end
      ST_TX: begin
        if (want_rx)
          state_d = ST_TURN;
      end
      default: state_d = ST_RX;
    endcase
  end

  // turn counter runs only while the state stays in turnaround
  always @* begin
    if (state_q == ST_TURN && state_d == ST_TURN)
      turn_d = turn_q + 4'h1;
    else
      turn_d = 4'h0;
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= ST_RX;
      turn_q <= 4'h0;
    end else begin
      state_q <= state_d;
      turn_q <= turn_d;
    end
  end

  // next values of the transceiver select pins
  always @* begin
    // RL7 suspend select
    low_power_hold_d = ctrl_q[`CTRL_LOW_POWER_HOLD_BIT];
    // RL8 pull-up attach
    attach_d = ctrl_q[`CTRL_ATTACH_BIT];
    // RL11 pull-up side
    speed_d = ctrl_q[`CTRL_SPEED_BIT];
    // RL5 RL6 input mode select
    mode_d = ctrl_q[`CTRL_DIFF_BIT];
  end

  // next drive of the line pins and the direction select
  always @* begin
    dir_rx_d = 1'b1;
    line_oe_n_d = 1'b1;
    line_plus_d = 1'b0;
    line_minus_d = 1'b0;
    case (state_d)
      ST_TX: begin
        // RL1 RL4 direction low only once turnaround is over
        dir_rx_d = 1'b0;
        // RL7 suspend keeps the pins released
        if (!ctrl_q[`CTRL_LOW_POWER_HOLD_BIT]) begin
          line_oe_n_d = 1'b0;
          // RL5 RL9 differential: data on both pins
          // RL6 RL10 single ended: plus carries data, minus high forces se0
          line_plus_d = txdata_q[`TX_PLUS_BIT];
          line_minus_d = txdata_q[`TX_MINUS_BIT];
        end
      end
      // RL2 RL3 receive and turnaround leave the pins to the transceiver
      ST_RX: dir_rx_d = 1'b1;
      ST_TURN: dir_rx_d = 1'b1;
      default: dir_rx_d = 1'b1;
    endcase
  end

  // transceiver control pins
  always @(posedge core_clk) begin
    if (!resetn) begin
      dir_rx_q <= 1'b1;
      low_power_hold_q <= 1'b0;
      attach_q <= 1'b0;
      speed_full_q <= 1'b0;
      mode_diff_q <= 1'b0;
      line_plus_level_o <= 1'b0;
      line_minus_level_o <= 1'b0;
      line_plus_level_oe_n <= 1'b1;
      line_minus_level_oe_n <= 1'b1;
    end else begin
      low_power_hold_q <= low_power_hold_d;
      attach_q <= attach_d;
      speed_full_q <= speed_d;
      mode_diff_q <= mode_d;
      // RL1 RL4 direction select
      dir_rx_q <= dir_rx_d;
      // RL2 RL7 both pins released or driven together
      line_plus_level_oe_n <= line_oe_n_d;
      line_minus_level_oe_n <= line_oe_n_d;
      line_plus_level_o <= line_plus_d;
      line_minus_level_o <= line_minus_d;
    end
  end
endmodule

// ---- hw/xcvr_ctrl_defines.vh ----
// register map, field positions, synchroniser depth and turnaround length of the transceiver controller
// assumes inclusion by bare name from the design files
`ifndef XCVR_CTRL_DEFINES_VH
`define XCVR_CTRL_DEFINES_VH
`define ADR_CTRL 4'h0
`define ADR_TXDATA 4'h1
`define ADR_STATUS 4'h2
`define ADR_RXHIST 4'h3
`define CTRL_RX_BIT 0
`define CTRL_LOW_POWER_HOLD_BIT 1
`define CTRL_ATTACH_BIT 2
`define CTRL_SPEED_BIT 3
`define CTRL_DIFF_BIT 4
`define CTRL_RESET 32'h0000_0001
`define TX_PLUS_BIT 0
`define TX_MINUS_BIT 1
`define ST_RX_BIT 0
`define ST_PLUS_BIT 1
`define ST_MINUS_BIT 2
`define ST_SE0_BIT 3
`define ST_FULL_BIT 4
`define ST_ILLEGAL_BIT 5
`define ST_TURN_BIT 6
`define SYNC_DEPTH 3
`define SYNC_PINS 3
`define TURN_CYCLES 4'h4
`endif

// ---- hw/pin_sync3.v ----
// three-stage synchroniser for one pin with agreement filter
// assumes an asynchronous pin and the core clock domain
`timescale 1ns/1ps
`include "xcvr_ctrl_defines.vh"
module pin_sync3 (
  input wire core_clk, // core clock
  input wire resetn, // synchronous reset, active low
  input wire pin_in, // raw pin level
  output reg level_q // filtered level
);
  reg [`SYNC_DEPTH-1:0] sync_q;
  always @(posedge core_clk) begin
    if (!resetn) begin
      sync_q <= {`SYNC_DEPTH{1'b0}};
      level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[`SYNC_DEPTH-2:0], pin_in};
      // level changes only once stages two and three agree
      if (sync_q[1] == sync_q[2])
        level_q <= sync_q[2];
    end
  end
endmodule

// ---- bench/xcvr_ctrl_monitor.sv ----
// port checker for the transceiver controller
// assumes it is bound onto xcvr_ctrl
`timescale 1ns/1ps
module xcvr_ctrl_monitor (
  input wire logic core_clk, // clock
  input wire logic resetn, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o, // ack
  input wire logic dir_rx_q, // direction
  input wire logic low_power_hold_q, // suspend
  input wire logic line_plus_level_oe_n, // plus enable
  input wire logic line_minus_level_oe_n // minus enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_PULSE: assert property (req_s |=> pulse_s)
    else $error("ack not one cycle after request");
  AST_RX_FLOAT: assert property (
    dir_rx_q |-> line_plus_level_oe_n && line_minus_level_oe_n) else $error("pins driven in receive");
  AST_TX_GATE: assert property (
    !line_plus_level_oe_n |-> !dir_rx_q && !low_power_hold_q) else $error("pins driven outside transmit");
  AST_OE_PAIR: assert property (
    line_plus_level_oe_n == line_minus_level_oe_n) else $error("pin enables differ");
  AST_LOW_POWER_HOLD_FLOAT: assert property (
    low_power_hold_q |-> line_plus_level_oe_n && line_minus_level_oe_n) else $error("pins driven in suspend");
endmodule

// ---- bench/xcvr_model.sv ----
// behavioural transceiver on the far side of the controller
// assumes resolved pin levels from the bench
`timescale 1ns/1ps
module xcvr_model (
  input wire logic dir_rx_q, // direction
  input wire logic low_power_hold_q, // suspend
  input wire logic attach_q, // attach
  input wire logic speed_full_q, // speed
  input wire logic mode_diff_q, // mode
  input wire logic plus_w, // plus pin
  input wire logic minus_w, // minus pin
  input wire logic dp_host, // host d+
  input wire logic dm_host, // host d-
  output logic dev_en, // line pins driven
  output logic rx_diff_level, // rx level
  output logic dp, // bus d+
  output logic dm, // bus d-
  output logic pu_dp, // pull-up on d+
  output logic pu_dm // pull-up on d-
);
  logic tx;
  logic rcv_q = 1'b0;
  assign tx = !low_power_hold_q && !dir_rx_q;
  assign dev_en = !tx;
  assign dp = !tx ? dp_host : mode_diff_q ? plus_w : plus_w && !minus_w;
  assign dm = !tx ? dm_host : mode_diff_q ? minus_w : !plus_w && !minus_w;
  always @* begin
    if (low_power_hold_q)
      rcv_q = 1'b0;
    else if (dp ^ dm)
      rcv_q = dp;
  end
  assign rx_diff_level = rcv_q;
  assign pu_dp = attach_q && speed_full_q;
  assign pu_dm = attach_q && !speed_full_q;
endmodule

// ---- bench/xcvr_ctrl_bench.sv ----
// self-checking bench for the transceiver controller
// assumes xcvr_ctrl, xcvr_model and the monitor are compiled first
`timescale 1ns/1ps
`include "xcvr_ctrl_defines.vh"
module xcvr_ctrl_bench;
  logic core_clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, dir_rx_q, low_power_hold_q, attach_q, speed_full_q, mode_diff_q;
  logic line_plus_level_o, line_plus_level_oe_n, line_minus_level_o, line_minus_level_oe_n;
  logic dp_host = 1'b0, dm_host = 1'b0, dev_en, rx_diff_level, dp, dm, pu_dp, pu_dm;
  wire plus_w, minus_w, line_plus_level_i, line_minus_level_i;
  int failures = 0, checks = 0;
  logic [5:0] rows [5] = '{6'h23, 6'h09, 6'h14, 6'h08, 6'h23};
  // a line driven by neither controller nor transceiver shows the inverse of the controller value
  assign plus_w = !line_plus_level_oe_n ? line_plus_level_o : dev_en ? dp : !line_plus_level_o;
  assign minus_w = !line_minus_level_oe_n ? line_minus_level_o : dev_en ? dm : !line_minus_level_o;
  assign line_plus_level_i = plus_w;
  assign line_minus_level_i = minus_w;
  xcvr_ctrl u_dut (.*);
  xcvr_model u_model (.*);
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #40000;
    failures++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    bus(1'b0, `ADR_CTRL, 32'h0);
    chk(rd, `CTRL_RESET);
    chk({line_plus_level_oe_n, line_minus_level_oe_n}, 2'b11);
    chk({pu_dp, pu_dm}, 2'b00);
    // receive decode rows: bus pair, then status low nibble
    foreach (rows[i]) begin
      dp_host <= rows[i][5];
      dm_host <= rows[i][4];
      repeat (10) @(posedge core_clk);
      bus(1'b0, `ADR_STATUS, 32'h0);
      chk(rd[3:0], rows[i][3:0]);
    end
    bus(1'b0, `ADR_RXHIST, 32'h0);
    chk(rd, 32'h05);
    // suspend forces the rx level low
    bus(1'b1, `ADR_CTRL, 32'h07);
    repeat (10) @(posedge core_clk);
    bus(1'b0, `ADR_STATUS, 32'h0);
    chk(rd[0], 1'b0);
    chk(line_plus_level_oe_n, 1'b1);
    chk({low_power_hold_q, line_minus_level_oe_n}, 2'b11);
    chk({pu_dp, pu_dm}, 2'b01);
    // differential then single-ended transmit
    for (int m = 1; m >= 0; m--) begin
      bus(1'b1, `ADR_CTRL, {27'h0, m[0], 4'hc});
      repeat (12) @(posedge core_clk);
      chk({dir_rx_q, mode_diff_q, pu_dp, pu_dm}, {1'b0, m[0], 2'b10});
      for (int t = 0; t < 3; t++) begin
        bus(1'b1, `ADR_TXDATA, t);
        repeat (3) @(posedge core_clk);
        chk({dm, dp}, m ? t[1:0] : 2'(6'h06 >> (2 * t)));
      end
    end
    // reset in mid-run returns the pins to receive
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({dir_rx_q, low_power_hold_q, attach_q, line_plus_level_oe_n, line_minus_level_oe_n}, 5'h13);
    resetn <= 1'b1;
    bus(1'b0, `ADR_CTRL, 32'h0);
    chk(rd, `CTRL_RESET);
    bus(1'b0, 4'hf, 32'h0);
    chk(rd, 32'h0);
    conclude;
  end
endmodule
bind xcvr_ctrl xcvr_ctrl_monitor u_mon (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dir_rx_q(dir_rx_q), .low_power_hold_q(low_power_hold_q),
  .line_plus_level_oe_n(line_plus_level_oe_n), .line_minus_level_oe_n(line_minus_level_oe_n));
